// File: cod_pkg.sv
// Constants and types shared by the opcode decode slice
package cod_pkg;
   // Register byte offsets
   localparam logic [7:0] COD_OFF_OPCODE = 8'h00;
   localparam logic [7:0] COD_OFF_OPER = 8'h04;
   localparam logic [7:0] COD_OFF_ACC = 8'h08;
   localparam logic [7:0] COD_OFF_IDX = 8'h0C;
   localparam logic [7:0] COD_OFF_FLAGS = 8'h10;
   localparam logic [7:0] COD_OFF_PC = 8'h14;
   localparam logic [7:0] COD_OFF_MEMDATA = 8'h18;
   localparam logic [7:0] COD_OFF_STATUS = 8'h1C;
   localparam logic [7:0] COD_OFF_EA = 8'h20;
   // Flag bit positions in condition_flags_register
   localparam int COD_FLAG_H = 4;
   localparam int COD_FLAG_I = 3;
   localparam int COD_FLAG_N = 2;
   localparam int COD_FLAG_Z = 1;
   localparam int COD_FLAG_C = 0;
   // Reset values
   localparam logic [4:0] COD_FLAGS_RST = 5'h08;
   localparam logic [7:0] COD_BYTE_RST = 8'h00;
   localparam logic [15:0] COD_WORD_RST = 16'h0000;
   // Opcodes handled here
   localparam logic [7:0] COD_OP_TEST_DIR = 8'h3D;
   localparam logic [7:0] COD_OP_TEST_A = 8'h4D;
   localparam logic [7:0] COD_OP_TEST_X = 8'h5D;
   localparam logic [7:0] COD_OP_TEST_SOFS = 8'h6D;
   localparam logic [7:0] COD_OP_TEST_IX = 8'h7D;
   localparam logic [7:0] COD_OP_I2A = 8'h9F;
   localparam logic [7:0] COD_OP_A2I = 8'h97;
   localparam logic [7:0] COD_OP_WAIT = 8'h8F;
   localparam logic [7:0] COD_OP_STOP = 8'h8E;
   // Cycle counts
   localparam logic [3:0] COD_CYC_TEST_DIR = 4'h4;
   localparam logic [3:0] COD_CYC_TEST_REG = 4'h3;
   localparam logic [3:0] COD_CYC_TEST_SOFS = 4'h5;
   localparam logic [3:0] COD_CYC_TEST_IX = 4'h4;
   localparam logic [3:0] COD_CYC_XFER = 4'h2;
   localparam logic [3:0] COD_CYC_WAIT = 4'h2;
   localparam logic [3:0] COD_CYC_STOP = 4'h2;
   localparam logic [3:0] COD_CYC_OTHER = 4'h1;

   typedef enum logic [5:0] {
      COD_GRP_BTB = 6'b000001,
      COD_GRP_BSC = 6'b000010,
      COD_GRP_BRANCH = 6'b000100,
      COD_GRP_RMW = 6'b001000,
      COD_GRP_CTRL = 6'b010000,
      COD_GRP_REGMEM = 6'b100000
   } cod_group_t;

   typedef enum logic [7:0] {
      COD_MODE_DIRECT = 8'b00000001,
      COD_MODE_RELATIVE = 8'b00000010,
      COD_MODE_BIT_BRANCH = 8'b00000100,
      COD_MODE_IMPLIED = 8'b00001000,
      COD_MODE_IMMEDIATE = 8'b00010000,
      COD_MODE_LONG_ADDR = 8'b00100000,
      COD_MODE_LONG_OFS = 8'b01000000,
      COD_MODE_SHORT_OFS = 8'b10000000
   } cod_mode_t;

   typedef enum logic [8:0] {
      COD_K_NONE = 9'b000000001,
      COD_K_TEST_MEM = 9'b000000010,
      COD_K_TEST_A = 9'b000000100,
      COD_K_TEST_X = 9'b000001000,
      COD_K_I2A = 9'b000010000,
      COD_K_A2I = 9'b000100000,
      COD_K_WAIT = 9'b001000000,
      COD_K_STOP = 9'b010000000,
      COD_K_INDEX = 9'b100000000
   } cod_kind_t;

   typedef enum logic [3:0] {
      COD_ST_IDLE = 4'b0001,
      COD_ST_RUN = 4'b0010,
      COD_ST_WAIT = 4'b0100,
      COD_ST_STOP = 4'b1000
   } cod_state_t;
endpackage

// File: cod_decode.sv
// Combinational opcode classifier: group, addressing mode, length, cycles
`timescale 1ns/1ps
module cod_decode
   import cod_pkg::*;
(
   input wire logic [7:0] opcode, // Opcode byte
   output cod_group_t group, // Opcode column group
   output cod_mode_t mode, // Addressing mode
   output logic [1:0] nbytes, // Operand bytes after the opcode
   output logic [3:0] cycles, // Cycles to complete
   output cod_kind_t kind // Operation handled by this slice
);
   always_comb begin
      unique case (opcode[7:4])
         4'h0: group = COD_GRP_BTB;
         4'h1: group = COD_GRP_BSC;
         4'h2: group = COD_GRP_BRANCH;
         4'h3, 4'h4, 4'h5, 4'h6, 4'h7: group = COD_GRP_RMW;
         4'h8, 4'h9: group = COD_GRP_CTRL;
         default: group = COD_GRP_REGMEM;
      endcase
      unique case (opcode[7:4])
         4'h0: begin
            mode = COD_MODE_BIT_BRANCH;
            nbytes = 2'd2;
         end
         4'h1, 4'h3, 4'hB: begin
            mode = COD_MODE_DIRECT;
            nbytes = 2'd1;
         end
         4'h2: begin
            mode = COD_MODE_RELATIVE;
            nbytes = 2'd1;
         end
         4'h6, 4'hE: begin
            mode = COD_MODE_SHORT_OFS;
            nbytes = 2'd1;
         end
         4'hA: begin
            mode = COD_MODE_IMMEDIATE;
            nbytes = 2'd1;
         end
         4'hC: begin
            mode = COD_MODE_LONG_ADDR;
            nbytes = 2'd2;
         end
         4'hD: begin
            mode = COD_MODE_LONG_OFS;
            nbytes = 2'd2;
         end
         4'h7, 4'hF: begin
            mode = COD_MODE_SHORT_OFS;
            nbytes = 2'd0;
         end
         default: begin
            mode = COD_MODE_IMPLIED;
            nbytes = 2'd0;
         end
      endcase
      // No-offset indexed shares the short-offset adder with a zero byte
      if (opcode[7:4] == 4'h7 || opcode[7:4] == 4'hF) begin
         mode = COD_MODE_SHORT_OFS;
      end
      cycles = COD_CYC_OTHER;
      kind = COD_K_NONE;
      unique case (opcode)
         COD_OP_TEST_DIR: begin
            cycles = COD_CYC_TEST_DIR;
            kind = COD_K_TEST_MEM;
         end
         COD_OP_TEST_A: begin
            cycles = COD_CYC_TEST_REG;
            kind = COD_K_TEST_A;
         end
         COD_OP_TEST_X: begin
            cycles = COD_CYC_TEST_REG;
            kind = COD_K_TEST_X;
         end
         COD_OP_TEST_SOFS: begin
            cycles = COD_CYC_TEST_SOFS;
            kind = COD_K_TEST_MEM;
         end
         COD_OP_TEST_IX: begin
            cycles = COD_CYC_TEST_IX;
            kind = COD_K_TEST_MEM;
         end
         COD_OP_I2A: begin
            cycles = COD_CYC_XFER;
            kind = COD_K_I2A;
         end
         COD_OP_A2I: begin
            cycles = COD_CYC_XFER;
            kind = COD_K_A2I;
         end
         COD_OP_WAIT: begin
            cycles = COD_CYC_WAIT;
            kind = COD_K_WAIT;
         end
         COD_OP_STOP: begin
            cycles = COD_CYC_STOP;
            kind = COD_K_STOP;
         end
         default: begin
            cycles = COD_CYC_OTHER;
            kind = COD_K_NONE;
         end
      endcase
   end
endmodule

// File: cod_core.sv
// Opcode decode slice with APB register access and execution sequencer
`timescale 1ns/1ps
// Summary of operation
// - Test-operand instructions compare the operand with zero, set N and Z, store nothing, keep H, I and C.
// - Test opcodes 3D direct 4 cycles, 4D accumulator and 5D index 3 cycles, 6D short offset 5, 7D indexed 4.
// - Opcode 9F copies the index into the accumulator in 2 cycles, no operand, flags unchanged.
// - Opcode 8F clears the interrupt mask and halts the CPU clock until an interrupt, 2 cycles.
// - Short-offset indexed mode has one operand byte added to the index to form the address.
// - Long-offset indexed mode has two bytes, high first, forming an offset added to the index.
// - Long-address mode fetches two bytes, high first, used directly as the address.
// - Bit-test-and-branch carries a direct address byte then a signed offset added to the program counter.
// - Opcode 8E stops the oscillator and clears the interrupt mask so the interrupt pin can wake it, 2 cycles.
// - Opcode 97 copies the accumulator into the index in 2 cycles, flags unchanged.
module cod_core
   import cod_pkg::*;
(
   input wire logic pclk, // APB clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic irq_n, // External interrupt pin, active low
   output logic cpu_clk_halt, // CPU clock halted by wait
   output logic osc_stopped // Oscillator stopped
);
   cod_state_t state_q;
   logic [7:0] opc_q, acc_q, idx_q, mem_q, op1_q, op2_q;
   logic [4:0] flags_q;
   logic [15:0] pc_q, ea_q, tgt_q;
   logic [3:0] cnt_q;
   logic irq_s1_q, irq_s2_q;
   cod_group_t grp;
   cod_mode_t mode;
   logic [1:0] nbytes;
   logic [3:0] cycles;
   cod_kind_t kind;
   logic wr_acc, rd_acc, mapped, busy, start, done;
   logic [7:0] test_val;
   logic [15:0] ea_d, tgt_d;

   cod_decode u_dec (
      .opcode(opc_q),
      .group(grp),
      .mode(mode),
      .nbytes(nbytes),
      .cycles(cycles),
      .kind(kind)
   );

   // Interrupt pin crosses from outside, two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_s1_q <= 1'b0;
         irq_s2_q <= 1'b0;
      end else begin
         irq_s1_q <= ~irq_n;
         irq_s2_q <= irq_s1_q;
      end
   end

   assign busy = (state_q != COD_ST_IDLE);
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign mapped = (paddr <= COD_OFF_EA) && (paddr[1:0] == 2'b00);
   // Writes are refused while an instruction runs, so completion never races software
   assign start = wr_acc && !busy && paddr == COD_OFF_OPCODE;
   assign done = (state_q == COD_ST_RUN) && (cnt_q == cycles);
   assign pready = 1'b1;
   assign pslverr = psel && penable && (!mapped || (pwrite && busy));
   assign cpu_clk_halt = (state_q == COD_ST_WAIT);
   assign osc_stopped = (state_q == COD_ST_STOP);

   always_comb begin
      unique case (mode)
         COD_MODE_SHORT_OFS: ea_d = idx_q + (nbytes == 2'd0 ? 16'h0000 : {8'h00, op1_q});
         COD_MODE_LONG_OFS: ea_d = {op1_q, op2_q} + {8'h00, idx_q};
         COD_MODE_LONG_ADDR: ea_d = {op1_q, op2_q};
         COD_MODE_DIRECT, COD_MODE_BIT_BRANCH: ea_d = {8'h00, op1_q};
         default: ea_d = COD_WORD_RST;
      endcase
      tgt_d = pc_q + {{8{op2_q[7]}}, op2_q};
      unique case (kind)
         COD_K_TEST_A: test_val = acc_q;
         COD_K_TEST_X: test_val = idx_q;
         default: test_val = mem_q;
      endcase
   end

   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= COD_ST_IDLE;
         cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            COD_ST_IDLE: begin
               if (start) begin
                  state_q <= COD_ST_RUN;
                  cnt_q <= 4'h1;
               end
            end
            COD_ST_RUN: begin
               cnt_q <= cnt_q + 4'h1;
               if (done) begin
                  cnt_q <= 4'h0;
                  if (kind == COD_K_WAIT) begin
                     state_q <= COD_ST_WAIT;
                  end else if (kind == COD_K_STOP) begin
                     state_q <= COD_ST_STOP;
                  end else begin
                     state_q <= COD_ST_IDLE;
                  end
               end
            end
            COD_ST_WAIT, COD_ST_STOP: begin
               if (irq_s2_q) begin
                  state_q <= COD_ST_IDLE;
               end
            end
            default: state_q <= COD_ST_IDLE;
         endcase
      end
   end

   // Software-visible registers and instruction effects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opc_q <= COD_BYTE_RST;
         acc_q <= COD_BYTE_RST;
         idx_q <= COD_BYTE_RST;
         mem_q <= COD_BYTE_RST;
         op1_q <= COD_BYTE_RST;
         op2_q <= COD_BYTE_RST;
         flags_q <= COD_FLAGS_RST;
         pc_q <= COD_WORD_RST;
         ea_q <= COD_WORD_RST;
         tgt_q <= COD_WORD_RST;
      end else if (wr_acc && !busy) begin
         unique case (paddr)
            COD_OFF_OPCODE: opc_q <= pwdata[7:0];
            COD_OFF_OPER: begin
               op1_q <= pwdata[7:0];
               op2_q <= pwdata[15:8];
            end
            COD_OFF_ACC: acc_q <= pwdata[7:0];
            COD_OFF_IDX: idx_q <= pwdata[7:0];
            COD_OFF_FLAGS: flags_q <= pwdata[4:0];
            COD_OFF_PC: pc_q <= pwdata[15:0];
            COD_OFF_MEMDATA: mem_q <= pwdata[7:0];
            default: ;
         endcase
      end else if (done) begin
         ea_q <= ea_d;
         tgt_q <= tgt_d;
         unique case (kind)
            COD_K_TEST_MEM, COD_K_TEST_A, COD_K_TEST_X: begin
               flags_q[COD_FLAG_N] <= test_val[7];
               flags_q[COD_FLAG_Z] <= (test_val == 8'h00);
            end
            COD_K_I2A: acc_q <= idx_q;
            COD_K_A2I: idx_q <= acc_q;
            COD_K_WAIT, COD_K_STOP: flags_q[COD_FLAG_I] <= 1'b0;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            COD_OFF_OPCODE: prdata <= {24'h000000, opc_q};
            COD_OFF_OPER: prdata <= {16'h0000, op2_q, op1_q};
            COD_OFF_ACC: prdata <= {24'h000000, acc_q};
            COD_OFF_IDX: prdata <= {24'h000000, idx_q};
            COD_OFF_FLAGS: prdata <= {27'h0000000, flags_q};
            COD_OFF_PC: prdata <= {16'h0000, pc_q};
            COD_OFF_MEMDATA: prdata <= {24'h000000, mem_q};
            COD_OFF_STATUS: prdata <= {6'h00, grp, mode, 2'b00, nbytes, cycles, state_q};
            COD_OFF_EA: prdata <= {tgt_q, ea_q};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   a_test_flags: assert property (@(posedge pclk) disable iff (!presetn)
      done && (kind == COD_K_TEST_A) |=> flags_q[COD_FLAG_Z] == ($past(acc_q) == 8'h00)
         && flags_q[COD_FLAG_N] == $past(acc_q[7])) else $error("test flags wrong");
   a_test_keep: assert property (@(posedge pclk) disable iff (!presetn)
      done && kind inside {COD_K_TEST_MEM, COD_K_TEST_A, COD_K_TEST_X} |=> $stable(acc_q) && $stable(idx_q)
         && $stable(flags_q[COD_FLAG_H]) && $stable(flags_q[COD_FLAG_I]) && $stable(flags_q[COD_FLAG_C]))
      else $error("test changed state");
   a_test_dir_cyc: assert property (@(posedge pclk) disable iff (!presetn)
      start && pwdata[7:0] == 8'h3D |-> ##4 done) else $error("direct test cycles");
   a_test_sofs_cyc: assert property (@(posedge pclk) disable iff (!presetn)
      start && pwdata[7:0] == 8'h6D |-> ##1 !done [*4] ##1 done) else $error("indexed test cycles");
   a_i2a_copy: assert property (@(posedge pclk) disable iff (!presetn)
      start && pwdata[7:0] == 8'h9F |-> ##2 done ##1 acc_q == idx_q && $stable(flags_q))
      else $error("index to acc copy");
   a_a2i_copy: assert property (@(posedge pclk) disable iff (!presetn)
      start && pwdata[7:0] == 8'h97 |-> ##2 done ##1 idx_q == acc_q && $stable(flags_q))
      else $error("acc to index copy");
   a_wait_halt: assert property (@(posedge pclk) disable iff (!presetn)
      start && pwdata[7:0] == 8'h8F |-> ##3 cpu_clk_halt && !flags_q[COD_FLAG_I]) else $error("wait halt");
   a_stop_osc: assert property (@(posedge pclk) disable iff (!presetn)
      start && pwdata[7:0] == 8'h8E |-> ##3 osc_stopped && !flags_q[COD_FLAG_I]) else $error("stop osc");
   a_wake_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (cpu_clk_halt || osc_stopped) && irq_s2_q |=> state_q == COD_ST_IDLE) else $error("wake failed");
   a_ea_long: assert property (@(posedge pclk) disable iff (!presetn)
      done && mode == COD_MODE_LONG_OFS |=> ea_q == {$past(op1_q), $past(op2_q)} + {8'h00, $past(idx_q)})
      else $error("long offset address");
   a_grp_nib: assert property (@(posedge pclk) disable iff (!presetn)
      opc_q[7:4] == 4'h9 |-> grp == COD_GRP_CTRL) else $error("group decode");
endmodule

// File: cod_core_tb.sv
// Self-checking testbench for the opcode decode slice over APB
`timescale 1ns/1ps
module cod_core_tb;
   import cod_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq_n = 1'b1;
   logic cpu_clk_halt;
   logic osc_stopped;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic er;
   logic [7:0] v, op, x;
   logic [4:0] f;
   logic [15:0] pc, ofs;
   logic [3:0] st;

   always #12.5 pclk = ~pclk;

   cod_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_n(irq_n), .cpu_clk_halt(cpu_clk_halt), .osc_stopped(osc_stopped));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Holds the request until pready is seen high, then leaves one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic poll(input logic [3:0] want);
      int n;
      n = 0;
      do begin
         apb(1'b0, COD_OFF_STATUS, 32'h0);
         n++;
      end while (rd[3:0] !== want && n < 40);
      st = rd[3:0];
      if (st !== want) begin
         bad_count++;
         $display("Error state expected %h seen %h", want, st);
      end
   endtask

   function automatic logic [3:0] cyc(input logic [7:0] o);
      case (o)
         8'h3D: return 4'h4;
         8'h4D, 8'h5D: return 4'h3;
         8'h6D: return 4'h5;
         8'h7D: return 4'h4;
         default: return 4'h2;
      endcase
   endfunction

   function automatic logic [5:0] grp(input logic [7:0] o);
      case (o[7:4])
         4'h0: return 6'h01;
         4'h1: return 6'h02;
         4'h2: return 6'h04;
         4'h3, 4'h4, 4'h5, 4'h6, 4'h7: return 6'h08;
         4'h8, 4'h9: return 6'h10;
         default: return 6'h20;
      endcase
   endfunction

   function automatic logic [1:0] nby(input logic [7:0] o);
      case (o[7:4])
         4'h0, 4'hC, 4'hD: return 2'h2;
         4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hF: return 2'h0;
         default: return 2'h1;
      endcase
   endfunction

   function automatic logic [7:0] md(input logic [7:0] o);
      case (o[7:4])
         4'h0: return 8'h04;
         4'h1, 4'h3, 4'hB: return 8'h01;
         4'h2: return 8'h02;
         4'h6, 4'h7, 4'hE, 4'hF: return 8'h80;
         4'hA: return 8'h10;
         4'hC: return 8'h20;
         4'hD: return 8'h40;
         default: return 8'h08;
      endcase
   endfunction

   function automatic logic [15:0] ea(input logic [7:0] o, input logic [15:0] b, input logic [7:0] xi);
      case (o[7:4])
         4'hC: return {b[7:0], b[15:8]};
         4'hD: return {b[7:0], b[15:8]} + {8'h00, xi};
         4'hE: return {8'h00, b[7:0]} + {8'h00, xi};
         4'hF: return {8'h00, xi};
         4'h2, 4'hA: return 16'h0000;
         default: return {8'h00, b[7:0]};
      endcase
   endfunction

   task automatic stop_test;
      $display("Checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Whole run is a few thousand cycles; this leaves ample margin
   initial begin
      #(25 * 40000);
      bad_count++;
      stop_test();
   end

   initial begin
      logic [7:0] tops[9];
      void'($urandom(32'h3620AA5E));
      tops = '{8'h00, 8'h10, 8'h20, 8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'hE0, 8'hF0};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, COD_OFF_FLAGS, 32'h0);
      chk("flags reset", 32'h08, rd);
      apb(1'b0, COD_OFF_ACC, 32'h0);
      chk("acc reset", 32'h0, rd);
      chk("ready level", 32'h1, {31'h0, pready});
      apb(1'b0, 8'h24, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      apb(1'b1, 8'h01, 32'h0);
      chk("unaligned err", 32'h1, {31'h0, er});
      $display("Test reset and map done");
      // Only the tested operand holds v; the others flip its sign so a wrong select shows
      foreach (tops[i]) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'h7F : 8'($urandom());
         for (int k = 0; k < 5; k++) begin
            op = 8'h3D + 8'(k * 16);
            f = 5'($urandom());
            apb(1'b1, COD_OFF_FLAGS, {27'h0, f});
            apb(1'b1, COD_OFF_ACC, {24'h0, k == 1 ? v : v ^ 8'h80});
            apb(1'b1, COD_OFF_IDX, {24'h0, k == 2 ? v : v ^ 8'h80});
            apb(1'b1, COD_OFF_MEMDATA, {24'h0, (k == 1 || k == 2) ? v ^ 8'h80 : v});
            apb(1'b1, COD_OFF_OPCODE, {24'h0, op});
            poll(4'h1);
            apb(1'b0, COD_OFF_FLAGS, 32'h0);
            chk("test flags", {27'h0, f[4:3], v[7], v == 8'h00, f[0]}, rd);
            apb(1'b0, COD_OFF_MEMDATA, 32'h0);
            chk("test no store", {24'h0, (k == 1 || k == 2) ? v ^ 8'h80 : v}, rd);
            apb(1'b0, COD_OFF_STATUS, 32'h0);
            chk("test cycles", {28'h0, cyc(op)}, {28'h0, rd[7:4]});
            chk("test group", {26'h0, grp(op)}, {26'h0, rd[25:20]});
         end
      end
      $display("Test operand tests done");
      for (int k = 0; k < 4; k++) begin
         op = k[0] ? COD_OP_A2I : COD_OP_I2A;
         v = 8'($urandom());
         x = 8'($urandom());
         f = 5'($urandom());
         apb(1'b1, COD_OFF_FLAGS, {27'h0, f});
         apb(1'b1, COD_OFF_ACC, {24'h0, v});
         apb(1'b1, COD_OFF_IDX, {24'h0, x});
         apb(1'b1, COD_OFF_OPCODE, {24'h0, op});
         poll(4'h1);
         apb(1'b0, k[0] ? COD_OFF_IDX : COD_OFF_ACC, 32'h0);
         chk("transfer value", {24'h0, k[0] ? v : x}, rd);
         apb(1'b0, COD_OFF_FLAGS, 32'h0);
         chk("transfer flags", {27'h0, f}, rd);
         apb(1'b0, COD_OFF_STATUS, 32'h0);
         chk("transfer cycles", 32'h2, {28'h0, rd[7:4]});
         chk("transfer bytes", 32'h0, {30'h0, rd[9:8]});
      end
      // A write landing while the five-cycle test still runs is refused
      apb(1'b1, COD_OFF_ACC, 32'h11);
      apb(1'b1, COD_OFF_OPCODE, {24'h0, COD_OP_TEST_SOFS});
      apb(1'b1, COD_OFF_ACC, 32'h22);
      chk("busy write err", 32'h1, {31'h0, er});
      poll(4'h1);
      apb(1'b0, COD_OFF_ACC, 32'h0);
      chk("busy write ignored", 32'h11, rd);
      $display("Test transfers and refusal done");
      for (int k = 0; k < 27; k++) begin
         op = tops[k % 9] | 8'($urandom_range(0, 11));
         ofs = 16'($urandom());
         pc = 16'($urandom());
         x = 8'($urandom());
         apb(1'b1, COD_OFF_OPER, {16'h0, ofs});
         apb(1'b1, COD_OFF_PC, {16'h0, pc});
         apb(1'b1, COD_OFF_IDX, {24'h0, x});
         apb(1'b1, COD_OFF_OPCODE, {24'h0, op});
         poll(4'h1);
         apb(1'b0, COD_OFF_EA, 32'h0);
         chk("effective address", {16'h0, ea(op, ofs, x)}, {16'h0, rd[15:0]});
         if (op[7:4] == 4'h0) begin
            chk("branch target", {16'h0, pc + {{8{ofs[15]}}, ofs[15:8]}}, {16'h0, rd[31:16]});
         end
         apb(1'b0, COD_OFF_STATUS, 32'h0);
         chk("operand bytes", {30'h0, nby(op)}, {30'h0, rd[9:8]});
         chk("address mode", {24'h0, md(op)}, {24'h0, rd[19:12]});
         chk("column group", {26'h0, grp(op)}, {26'h0, rd[25:20]});
      end
      $display("Test addressing done");
      for (int k = 0; k < 2; k++) begin
         op = k[0] ? COD_OP_STOP : COD_OP_WAIT;
         f = 5'($urandom()) | 5'h08;
         apb(1'b1, COD_OFF_FLAGS, {27'h0, f});
         apb(1'b1, COD_OFF_OPCODE, {24'h0, op});
         poll(k[0] ? 4'h8 : 4'h4);
         repeat (6) @(posedge pclk);
         chk("halt level", k[0] ? 32'h2 : 32'h1, {30'h0, osc_stopped, cpu_clk_halt});
         apb(1'b0, COD_OFF_FLAGS, 32'h0);
         chk("sleep flags", {27'h0, f & 5'h17}, rd);
         apb(1'b0, COD_OFF_STATUS, 32'h0);
         chk("sleep cycles", 32'h2, {28'h0, rd[7:4]});
         irq_n <= 1'b0;
         poll(4'h1);
         chk("wake state", 32'h1, {28'h0, st});
         chk("wake level", 32'h0, {30'h0, osc_stopped, cpu_clk_halt});
         irq_n <= 1'b1;
         repeat (4) @(posedge pclk);
      end
      $display("Test wait and stop done");
      stop_test();
   end
endmodule
